/* File: include/pfsr_pkg.sv */
// Constants, field positions and carrier types for the frequency select register block
package pfsr_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PFSR_ADDR_WD_CTL    = 8'h09;
    localparam logic [7:0] PFSR_ADDR_REC_N     = 8'h0B;
    localparam logic [7:0] PFSR_ADDR_REC_M     = 8'h0C;
    localparam logic [7:0] PFSR_ADDR_CPU_N     = 8'h0D;
    localparam logic [7:0] PFSR_ADDR_CPU_M     = 8'h0E;
    localparam logic [7:0] PFSR_ADDR_RSVD_ONES = 8'h0F;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PFSR_REC_SEL_BIT   = 7;
    localparam int PFSR_PROG_EN_BIT   = 7;
    localparam int PFSR_WD_RST_EN_BIT = 4;
    localparam int PFSR_FC_RST_EN_BIT = 3;
    localparam int PFSR_WD_STAT_BIT   = 2;
    localparam int PFSR_WATCHDOG_ENABLE_BIT     = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PFSR_RST_WD_CTL    = 8'h00;
    localparam logic [7:0] PFSR_RST_REC_N     = 8'h00;
    localparam logic [7:0] PFSR_RST_REC_M     = 8'h00;
    localparam logic [7:0] PFSR_RST_CPU_N     = 8'h00;
    localparam logic [7:0] PFSR_RST_CPU_M     = 8'h00;
    localparam logic [7:0] PFSR_RST_RSVD_ONES = 8'h03;
    localparam logic [4:0] PFSR_RST_STRAP     = 5'h00;
    localparam logic [7:0] PFSR_RD_UNMAPPED   = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int PFSR_CLK_PERIOD_NS   = 40;
    localparam int PFSR_WD_TIMEOUT_US   = 1000;
    localparam int PFSR_WD_TIMEOUT_CYC  = (PFSR_WD_TIMEOUT_US * 1000 + PFSR_CLK_PERIOD_NS - 1) / PFSR_CLK_PERIOD_NS;
    localparam int PFSR_RST_PULSE_NS    = 2000;
    localparam int PFSR_RST_PULSE_CYC   = (PFSR_RST_PULSE_NS + PFSR_CLK_PERIOD_NS - 1) / PFSR_CLK_PERIOD_NS;

    // Programmed CPU frequency range served by the synthesiser
    localparam int PFSR_PROG_MIN_MHZ    = 50;
    localparam int PFSR_PROG_MAX_MHZ    = 248;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PFSR_SRC_TABLE,
        PFSR_SRC_PROG_NM,
        PFSR_SRC_REC_NM
    } pfsr_src_t;

    typedef struct packed {
        pfsr_src_t  src;
        logic [4:0] table_sel;
        logic [4:0] ratio_sel;
        logic [7:0] n_value;
        logic [6:0] m_value;
    } pfsr_freq_cfg_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } pfsr_reg_wr_t;

endpackage

/* File: rtl/pfsr_down_timer.sv */
// Reloadable down counter giving a busy level and an expiry pulse
`timescale 1ns/10ps
module pfsr_down_timer #(
    parameter int COUNT = 16
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic start,
    input  wire logic stop,
    // Status
    output logic      busy,
    output logic      expire
);

    localparam int CW = $clog2(COUNT + 1);

    initial begin
        if (COUNT < 1) begin
            $error("pfsr_down_timer: COUNT must be at least 1");
        end
    end

    logic [CW-1:0] count_reg;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (stop) begin
            count_reg <= '0;
        end else if (start) begin
            count_reg <= CW'(COUNT);
        end else if (count_reg != '0) begin
            count_reg <= count_reg - CW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            expire <= 1'b0;
        end else begin
            expire <= !stop && !start && (count_reg == CW'(1));
        end
    end

    assign busy = (count_reg != '0);

endmodule // pfsr_down_timer

/* File: rtl/pfsr_src_sel.sv */
// Frequency source and ratio selection
`timescale 1ns/10ps
module pfsr_src_sel (
    // Operating state
    input  wire logic                    in_recovery,
    // Selections
    input  wire logic [4:0]              strap_freq_select,
    input  wire logic [4:0]              sw_freq_select,
    input  wire logic                    ratio_source_override,
    input  wire logic                    recovery_source_select,
    input  wire logic                    prog_freq_enable,
    // Divider values
    input  wire logic [7:0]              recovery_n_value,
    input  wire logic [6:0]              recovery_m_value,
    input  wire logic [7:0]              cpu_n_value,
    input  wire logic [6:0]              cpu_m_value,
    // Result
    output pfsr_pkg::pfsr_freq_cfg_t     cfg
);

    logic [4:0] sw_or_strap;

    // RULE_04: ratio source override
    assign sw_or_strap = ratio_source_override ? sw_freq_select : strap_freq_select;

    always_comb begin
        cfg           = '0;
        cfg.ratio_sel = sw_or_strap;
        cfg.table_sel = sw_or_strap;
        if (in_recovery) begin
            // RULE_01: recovery source choice
            if (recovery_source_select) begin
                // RULE_03: recovery N/M pair
                cfg.src     = pfsr_pkg::PFSR_SRC_REC_NM;
                cfg.n_value = recovery_n_value;
                cfg.m_value = recovery_m_value;
            end else begin
                cfg.src       = pfsr_pkg::PFSR_SRC_TABLE;
                cfg.table_sel = strap_freq_select;
            end
        end else if (prog_freq_enable) begin
            // RULE_07: programmable enable gate
            // RULE_08: CPU N/M pair
            cfg.src     = pfsr_pkg::PFSR_SRC_PROG_NM;
            cfg.n_value = cpu_n_value;
            cfg.m_value = cpu_m_value;
        end else begin
            cfg.src = pfsr_pkg::PFSR_SRC_TABLE;
        end
    end

endmodule // pfsr_src_sel

/* File: rtl/pfsr_top.sv */
// Programmable and recovery CPU frequency select registers with watchdog switch-over
//
// Function
// RULE_01: Recovery select: 0 strap, 1 recovery N/M
// RULE_02: Watchdog timeout switches to recovery frequency
// RULE_03: Recovery frequency from 8-bit N, 7-bit M
// RULE_04: Override picks strap or software ratio select
// RULE_05: Recovery N or M write changes frequency
// RULE_06: Host writes recovery N and M together
// RULE_07: Programmable enable gates programmed frequency
// RULE_08: Programmed frequency from CPU N and M
// RULE_09: CPU M write starts load; N not
// RULE_10: Programmed frequency range 50 to 248 MHz
// RULE_11: Host writes ones to reserved low bits
// RULE_12: Watchdog counts after change; disable reloads (here disable clears and stops the count)
// RULE_13: Optional reset pulse after frequency change
// RULE_14: Power-on clears all fields to strap selection; the reserved byte resets to 8'h03 instead
`timescale 1ns/10ps
module pfsr_top #(
    parameter int WD_TIMEOUT_CYCLES = pfsr_pkg::PFSR_WD_TIMEOUT_CYC,
    parameter int RST_PULSE_CYCLES  = pfsr_pkg::PFSR_RST_PULSE_CYC
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Byte register port from the serial interface engine
    input  wire pfsr_pkg::pfsr_reg_wr_t  reg_wr,
    input  wire logic [7:0]              reg_rd_addr,
    output logic [7:0]                   reg_rd_data,
    // Frequency select inputs
    input  wire logic [4:0]              strap_freq_select,
    input  wire logic [4:0]              sw_freq_select,
    input  wire logic                    ratio_source_override,
    // Synthesiser control
    output pfsr_pkg::pfsr_freq_cfg_t     freq_cfg,
    output logic                         freq_load,
    // System recovery
    output logic                         sys_reset_pulse,
    output logic                         wd_timeout_status,
    output logic                         in_recovery
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    initial begin
        if (WD_TIMEOUT_CYCLES < 2) begin
            $error("pfsr_top: WD_TIMEOUT_CYCLES must be at least 2");
        end
        if (RST_PULSE_CYCLES < 1) begin
            $error("pfsr_top: RST_PULSE_CYCLES must be at least 1");
        end
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum {
        PFSR_ST_NORMAL,
        PFSR_ST_RECOVERY
    } pfsr_state_t;

    pfsr_state_t              state_reg;
    pfsr_state_t              state_next;

    logic [7:0]               wd_ctl_reg;
    logic [7:0]               rec_n_reg;
    logic [7:0]               rec_m_reg;
    logic [7:0]               cpu_n_reg;
    logic [7:0]               cpu_m_reg;
    logic [7:0]               rsvd_ones_reg;
    logic [4:0]               strap_reg;
    logic                     strap_taken_reg;
    logic                     wd_status_reg;
    logic                     load_req_reg;
    logic                     load_req_next;
    logic                     freq_load_reg;
    logic [7:0]               rd_data_reg;
    pfsr_pkg::pfsr_freq_cfg_t cfg_reg;
    pfsr_pkg::pfsr_freq_cfg_t cfg_next;

    logic                     wr_wd_ctl;
    logic                     wr_rec_n;
    logic                     wr_rec_m;
    logic                     wr_cpu_n;
    logic                     wr_cpu_m;
    logic                     wr_rsvd;
    logic                     wd_enable;
    logic                     wd_expire;
    logic                     wd_busy;
    logic                     rst_pulse_start;
    logic                     rst_pulse_busy;

    // Write strobe for one byte address
    function automatic logic hit(input pfsr_pkg::pfsr_reg_wr_t w, input logic [7:0] a);
        hit = w.en && (w.addr == a);
    endfunction

    assign wr_wd_ctl = hit(reg_wr, pfsr_pkg::PFSR_ADDR_WD_CTL);
    assign wr_rec_n  = hit(reg_wr, pfsr_pkg::PFSR_ADDR_REC_N);
    assign wr_rec_m  = hit(reg_wr, pfsr_pkg::PFSR_ADDR_REC_M);
    assign wr_cpu_n  = hit(reg_wr, pfsr_pkg::PFSR_ADDR_CPU_N);
    assign wr_cpu_m  = hit(reg_wr, pfsr_pkg::PFSR_ADDR_CPU_M);
    assign wr_rsvd   = hit(reg_wr, pfsr_pkg::PFSR_ADDR_RSVD_ONES);

    assign wd_enable = wd_ctl_reg[pfsr_pkg::PFSR_WATCHDOG_ENABLE_BIT];

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Strap pins are sampled on the first edge after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_reg       <= pfsr_pkg::PFSR_RST_STRAP;
            strap_taken_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_reg       <= strap_freq_select;
            strap_taken_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // RULE_14: cleared on power-on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_ctl_reg <= pfsr_pkg::PFSR_RST_WD_CTL;
        end else if (wr_wd_ctl) begin
            wd_ctl_reg                              <= reg_wr.data;
            wd_ctl_reg[pfsr_pkg::PFSR_WD_STAT_BIT]  <= 1'b0;
        end
    end

    // Timeout status: a timeout in the clearing cycle keeps the bit set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_status_reg <= 1'b0;
        end else if (wd_expire) begin
            wd_status_reg <= 1'b1;
        end else if (wr_wd_ctl && reg_wr.data[pfsr_pkg::PFSR_WD_STAT_BIT]) begin
            wd_status_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Divider registers
    // ------------------------------------------------------------------
    // RULE_14: dividers and enables cleared on power-on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rec_n_reg <= pfsr_pkg::PFSR_RST_REC_N;
            rec_m_reg <= pfsr_pkg::PFSR_RST_REC_M;
        end else begin
            if (wr_rec_n) begin
                rec_n_reg <= reg_wr.data;
            end
            if (wr_rec_m) begin
                rec_m_reg <= reg_wr.data;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_n_reg <= pfsr_pkg::PFSR_RST_CPU_N;
            cpu_m_reg <= pfsr_pkg::PFSR_RST_CPU_M;
        end else begin
            if (wr_cpu_n) begin
                cpu_n_reg <= reg_wr.data;
            end
            if (wr_cpu_m) begin
                cpu_m_reg <= reg_wr.data;
            end
        end
    end

    // Reserved byte keeps what the host writes; its low bits default to one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsvd_ones_reg <= pfsr_pkg::PFSR_RST_RSVD_ONES;
        end else if (wr_rsvd) begin
            rsvd_ones_reg <= reg_wr.data;
        end
    end

    // ------------------------------------------------------------------
    // Operating state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PFSR_ST_NORMAL: begin
                // RULE_02: timeout enters recovery
                if (wd_expire) begin
                    state_next = PFSR_ST_RECOVERY;
                end
            end
            PFSR_ST_RECOVERY: begin
                // A new programmed load hands control back to software
                if (wr_cpu_m) begin
                    state_next = PFSR_ST_NORMAL;
                end
            end
            default: begin
                state_next = PFSR_ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= PFSR_ST_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Frequency load requests
    // ------------------------------------------------------------------
    always_comb begin
        load_req_next = 1'b0;
        // RULE_09: CPU M byte write loads
        if (wr_cpu_m) begin
            load_req_next = 1'b1;
        end
        // RULE_05: either recovery byte reloads
        if ((wr_rec_n || wr_rec_m) && state_reg == PFSR_ST_RECOVERY) begin
            load_req_next = 1'b1;
        end
        // RULE_02: switch-over on timeout
        if (wd_expire) begin
            load_req_next = 1'b1;
        end
    end

    // Load pulse trails the request by one edge so it meets the new config
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_req_reg  <= 1'b0;
            freq_load_reg <= 1'b0;
        end else begin
            load_req_reg  <= load_req_next;
            freq_load_reg <= load_req_reg;
        end
    end

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    pfsr_src_sel u_src_sel (
        .in_recovery            (state_reg == PFSR_ST_RECOVERY),
        .strap_freq_select      (strap_reg),
        .sw_freq_select         (sw_freq_select),
        .ratio_source_override  (ratio_source_override),
        .recovery_source_select (rec_m_reg[pfsr_pkg::PFSR_REC_SEL_BIT]),
        .prog_freq_enable       (cpu_m_reg[pfsr_pkg::PFSR_PROG_EN_BIT]),
        .recovery_n_value       (rec_n_reg),
        .recovery_m_value       (rec_m_reg[6:0]),
        .cpu_n_value            (cpu_n_reg),
        .cpu_m_value            (cpu_m_reg[6:0]),
        .cfg                    (cfg_next)
    );

    // RULE_10: N/M passed unclipped to synthesiser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= '0;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog timer
    // ------------------------------------------------------------------
    // RULE_12: start on change in normal state, disable clears the count
    pfsr_down_timer #(
        .COUNT (WD_TIMEOUT_CYCLES)
    ) u_wd_timer (
        .clk    (clk),
        .rst    (rst),
        .start  (freq_load_reg && wd_enable && state_reg == PFSR_ST_NORMAL),
        .stop   (!wd_enable),
        .busy   (wd_busy),
        .expire (wd_expire)
    );

    // ------------------------------------------------------------------
    // System reset pulse
    // ------------------------------------------------------------------
    // RULE_13: pulse after frequency change
    assign rst_pulse_start = (freq_load_reg && wd_ctl_reg[pfsr_pkg::PFSR_FC_RST_EN_BIT])
                           || (wd_expire && wd_ctl_reg[pfsr_pkg::PFSR_WD_RST_EN_BIT]);

    pfsr_down_timer #(
        .COUNT (RST_PULSE_CYCLES)
    ) u_rst_timer (
        .clk    (clk),
        .rst    (rst),
        .start  (rst_pulse_start),
        .stop   (1'b0),
        .busy   (rst_pulse_busy),
        .expire ()
    );

    // ------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= pfsr_pkg::PFSR_RD_UNMAPPED;
        end else if (reg_rd_addr == pfsr_pkg::PFSR_ADDR_WD_CTL) begin
            rd_data_reg                             <= wd_ctl_reg;
            rd_data_reg[pfsr_pkg::PFSR_WD_STAT_BIT] <= wd_status_reg;
        end else if (reg_rd_addr == pfsr_pkg::PFSR_ADDR_REC_N) begin
            rd_data_reg <= rec_n_reg;
        end else if (reg_rd_addr == pfsr_pkg::PFSR_ADDR_REC_M) begin
            rd_data_reg <= rec_m_reg;
        end else if (reg_rd_addr == pfsr_pkg::PFSR_ADDR_CPU_N) begin
            rd_data_reg <= cpu_n_reg;
        end else if (reg_rd_addr == pfsr_pkg::PFSR_ADDR_CPU_M) begin
            rd_data_reg <= cpu_m_reg;
        end else if (reg_rd_addr == pfsr_pkg::PFSR_ADDR_RSVD_ONES) begin
            rd_data_reg <= rsvd_ones_reg;
        end else begin
            rd_data_reg <= pfsr_pkg::PFSR_RD_UNMAPPED;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rd_data       = rd_data_reg;
    assign freq_cfg          = cfg_reg;
    assign freq_load         = freq_load_reg;
    assign sys_reset_pulse   = rst_pulse_busy;
    assign wd_timeout_status = wd_status_reg;
    assign in_recovery       = (state_reg == PFSR_ST_RECOVERY);

endmodule // pfsr_top

/* File: testbench/pfsr_props.sv */
// Port checker for the frequency select register block
`timescale 1ns/10ps
module pfsr_props #(
    parameter int WD_TIMEOUT_CYCLES = 8,
    parameter int RST_PULSE_CYCLES  = 3
) (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst,
    // Register port
    input wire pfsr_pkg::pfsr_reg_wr_t   reg_wr,
    input wire logic [7:0]               reg_rd_addr,
    input wire logic [7:0]               reg_rd_data,
    // Selections
    input wire logic [4:0]               strap_freq_select,
    input wire logic [4:0]               sw_freq_select,
    input wire logic                     ratio_source_override,
    // Results
    input wire pfsr_pkg::pfsr_freq_cfg_t freq_cfg,
    input wire logic                     freq_load,
    input wire logic                     sys_reset_pulse,
    input wire logic                     wd_timeout_status,
    input wire logic                     in_recovery
);
    logic [7:0] r [16];
    wire        wr_m = reg_wr.en && reg_wr.addr == pfsr_pkg::PFSR_ADDR_CPU_M;
    wire        wr_rec = reg_wr.en && reg_wr.addr inside {pfsr_pkg::PFSR_ADDR_REC_N, pfsr_pkg::PFSR_ADDR_REC_M};

    // Shadow of every byte written to addresses below 8'h10
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{default: 8'h00};
        end else if (reg_wr.en && reg_wr.addr < 8'h10) begin
            r[reg_wr.addr[3:0]] <= reg_wr.data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_cpu_m_load: assert property (wr_m |-> ##2 freq_load)
        else $error("no load after m write");
    a_load_cause: assert property (freq_load |-> in_recovery || $past(wr_m, 2))
        else $error("load without cause");
    a_rec_reload: assert property (wr_rec && in_recovery |-> ##2 freq_load)
        else $error("no recovery reload");
    a_rec_source: assert property (freq_load && in_recovery |-> freq_cfg.src ==
        (r[12][7] ? pfsr_pkg::PFSR_SRC_REC_NM : pfsr_pkg::PFSR_SRC_TABLE)) else $error("wrong recovery source");
    a_rec_values: assert property (freq_load && in_recovery && r[12][7] |->
        freq_cfg.n_value == r[11] && freq_cfg.m_value == r[12][6:0]) else $error("wrong recovery n m");
    a_prog_values: assert property (freq_load && !in_recovery && r[14][7] |->
        freq_cfg.src == pfsr_pkg::PFSR_SRC_PROG_NM && freq_cfg.n_value == r[13] && freq_cfg.m_value == r[14][6:0])
        else $error("wrong programmed n m");
    a_table_ratio: assert property (freq_load && !in_recovery && !r[14][7] |->
        freq_cfg.src == pfsr_pkg::PFSR_SRC_TABLE && freq_cfg.ratio_sel == freq_cfg.table_sel
        && freq_cfg.ratio_sel == ($past(ratio_source_override) ? $past(sw_freq_select) : strap_freq_select))
        else $error("wrong table select");
    a_fc_pulse: assert property (freq_load && r[9][3] |=> sys_reset_pulse)
        else $error("no reset pulse");
    a_wd_hold: assert property (freq_load && r[9][1] && !in_recovery |=> !in_recovery [*7])
        else $error("watchdog expired early");
    a_reset_state: assert property ($fell(rst) |-> freq_cfg == '0 && !in_recovery && !freq_load)
        else $error("reset state wrong");
    a_far_read: assert property (reg_rd_addr > 8'h0F |=> reg_rd_data == 8'h00)
        else $error("unmapped read not zero");
endmodule // pfsr_props

bind pfsr_top pfsr_props #(
    .WD_TIMEOUT_CYCLES(WD_TIMEOUT_CYCLES),
    .RST_PULSE_CYCLES (RST_PULSE_CYCLES)
) u_props (.*);

/* File: testbench/pfsr_host_model.sv */
// Serial host model that writes configuration bytes
`timescale 1ns/10ps
module pfsr_host_model (
    // Clock
    input wire logic                clk,
    // Byte writes
    output pfsr_pkg::pfsr_reg_wr_t  reg_wr
);
    initial reg_wr = '0;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == pfsr_pkg::PFSR_ADDR_RSVD_ONES) d[1:0] = 2'b11;
        @(posedge clk);
        reg_wr <= '{1'b1, a, d};
        @(posedge clk);
        // Released bus shows no stale byte
        reg_wr <= '{1'b0, ~a, ~d};
    endtask

    task automatic wr2(input logic [7:0] n, input logic [7:0] m);
        wr(pfsr_pkg::PFSR_ADDR_REC_N, n);
        wr(pfsr_pkg::PFSR_ADDR_REC_M, m);
    endtask
endmodule // pfsr_host_model

/* File: testbench/test_pfsr_top.sv */
// Self-checking testbench for the frequency select register block
`timescale 1ns/10ps
module test_pfsr_top;
    localparam pfsr_pkg::pfsr_src_t tb = pfsr_pkg::PFSR_SRC_TABLE;
    logic                     clk, rst, ovr, load, rpulse, wd_stat, in_rec;
    logic [4:0]               strap, sw;
    logic [7:0]               rd_addr, rd_data, d, nv, mv;
    pfsr_pkg::pfsr_reg_wr_t   reg_wr;
    pfsr_pkg::pfsr_freq_cfg_t cfg;
    int                       num_errors, checks_done, seed;
    logic [7:0]               ra [8] = '{8'h09, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h20, 8'hFF};

    pfsr_top #(.WD_TIMEOUT_CYCLES(8), .RST_PULSE_CYCLES(3)) DUT (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd_addr(rd_addr), .reg_rd_data(rd_data),
        .strap_freq_select(strap), .sw_freq_select(sw), .ratio_source_override(ovr),
        .freq_cfg(cfg), .freq_load(load), .sys_reset_pulse(rpulse), .wd_timeout_status(wd_stat),
        .in_recovery(in_rec));
    pfsr_host_model HOST (.clk(clk), .reg_wr(reg_wr));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #100000;
        num_errors++;
        final_report;
    end

    function automatic pfsr_pkg::pfsr_freq_cfg_t ex(pfsr_pkg::pfsr_src_t s, logic [4:0] t, logic [7:0] n,
                                                   logic [6:0] m);
        ex = '{s, t, ovr ? sw : strap, n, m};
    endfunction

    task chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task rd(logic [7:0] a);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        #1;
        d = rd_data;
    endtask

    task wl(pfsr_pkg::pfsr_freq_cfg_t e);
        int i;
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while (!load && i < 6);
        chk("freq_load", load, 1'b1);
        chk("freq_cfg", {cfg.src, cfg.ratio_sel, cfg.n_value, cfg.m_value},
            {e.src, e.ratio_sel, e.n_value, e.m_value});
        if (e.src == tb) chk("table_sel", cfg.table_sel, e.table_sel);
    endtask

    task ml(pfsr_pkg::pfsr_freq_cfg_t e);
        HOST.wr(8'h0E, 8'h00);
        wl(e);
    endtask

    task final_report;
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        seed = 36758;
        rst = 1'b1;
        rd_addr = 8'h00;
        strap = 5'h13;
        sw = 5'h00;
        ovr = 1'b0;
        num_errors = 0;
        checks_done = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("reset cfg", cfg, ex(tb, strap, 0, 0));
        for (int i = 0; i < 8; i++) begin
            rd(ra[i]);
            chk("reset byte", d, ra[i] == 8'h0F ? 8'h03 : 8'h00);
        end
        HOST.wr(8'h20, 8'hFF);
        HOST.wr(8'h0F, 8'hFC);
        rd(8'h0F);
        chk("reserved ones", d[1:0], 2'b11);
        for (int i = 0; i < 8; i++) begin
            nv = $random(seed);
            mv = $random(seed);
            mv[7] = i[0];
            ovr <= $random(seed);
            sw <= $random(seed);
            HOST.wr(8'h0D, nv);
            repeat (3) begin
                @(posedge clk);
                #1;
                chk("n only load", load, 1'b0);
            end
            HOST.wr(8'h0E, mv);
            wl(mv[7] ? ex(pfsr_pkg::PFSR_SRC_PROG_NM, 0, nv, mv[6:0]) : ex(tb, ovr ? sw : strap, 0, 0));
            rd(8'h0E);
            chk("m readback", d, mv);
        end
        HOST.wr2(8'hA5, 8'h9A);
        HOST.wr(8'h09, 8'h0A);
        ml(ex(tb, ovr ? sw : strap, 0, 0));
        @(posedge clk);
        #1;
        chk("reset pulse", rpulse, 1'b1);
        repeat (9) @(posedge clk);
        #1;
        chk("recovery", in_rec, 1'b1);
        wl(ex(pfsr_pkg::PFSR_SRC_REC_NM, 0, 8'hA5, 7'h1A));
        chk("timeout status", wd_stat, 1'b1);
        HOST.wr(8'h0B, 8'h3C);
        wl(ex(pfsr_pkg::PFSR_SRC_REC_NM, 0, 8'h3C, 7'h1A));
        HOST.wr(8'h09, 8'h04);
        rd(8'h09);
        chk("status cleared", d, 8'h00);
        ml(ex(tb, ovr ? sw : strap, 0, 0));
        ovr <= 1'b1;
        HOST.wr(8'h0C, 8'h00);
        HOST.wr(8'h09, 8'h02);
        ml(ex(tb, sw, 0, 0));
        repeat (10) @(posedge clk);
        wl(ex(tb, strap, 0, 0));
        HOST.wr(8'h09, 8'h04);
        ml(ex(tb, sw, 0, 0));
        HOST.wr(8'h09, 8'h02);
        ml(ex(tb, sw, 0, 0));
        HOST.wr(8'h09, 8'h00);
        repeat (20) @(posedge clk);
        #1;
        chk("stopped watchdog", in_rec, 1'b0);
        final_report;
    end
endmodule // test_pfsr_top
